// file: hw/wacdr_defs.vh
// constants for the wire adapter configuration descriptor rom
`ifndef WACDR_DEFS_VH
`define WACDR_DEFS_VH
`define WACDR_CFG_LEN          8'h09
`define WACDR_CFG_TYPE         8'h02
`define WACDR_OSC_TYPE         8'h07
`define WACDR_ATTR_ONE_BIT     7
`define WACDR_ATTR_SELF_BIT    6
`define WACDR_ATTR_WAKE_BIT    5
`define WACDR_MA_PER_UNIT      2
`define WACDR_SEC_LEN          8'h05
`define WACDR_SEC_TYPE         8'h0c
`define WACDR_ENC_LEN          8'h05
`define WACDR_ENC_TYPE         8'h0e
`define WACDR_ENC_COUNT        8'h02
`define WACDR_KEY_INDEX        8'h00
`define WACDR_IF_LEN           8'h09
`define WACDR_IF_TYPE          8'h04
`define WACDR_IF_NUM           8'h00
`define WACDR_IF_ALT           8'h00
`define WACDR_IF_NUM_EP        8'h03
`define WACDR_IF_CLASS         8'he0
`define WACDR_IF_SUBCLASS      8'h02
`define WACDR_IF_PROTOCOL      8'h01
`define WACDR_WA_LEN           8'h0e
`define WACDR_WA_TYPE          8'h21
`define WACDR_WA_RELEASE       16'h0100
`define WACDR_WA_ATTR          8'h00
`define WACDR_WA_POWER_GOOD    8'h00
`define WACDR_WA_REMOVABLE     8'h00
`define WACDR_EP_BYTES         8'h15
`define WACDR_MAX_LEN          8'h44
// apb register byte addresses
`define WACDR_REG_CTRL         12'h000
`define WACDR_REG_MAXPWR       12'h004
`define WACDR_REG_CLASS0       12'h008
`define WACDR_REG_CLASS1       12'h00c
`define WACDR_REG_STATUS       12'h010
`define WACDR_REG_READ         12'h014
// reset values
`define WACDR_RST_MAXPWR_HS    8'h32
`define WACDR_RST_MAXPWR_FS    8'h32
`define WACDR_RST_PORTS        8'h7f
`define WACDR_RST_PIPES        16'h0010
`define WACDR_RST_BLOCKS       16'h0080
`define WACDR_RST_BLK_CODE     8'h0a
`define WACDR_RST_IE_COUNT     8'h04
`define WACDR_RST_CFG_VALUE    8'h01
`define WACDR_RST_NUM_IF       8'h02
`endif

// file: hw/wacdr_sync.v
// three-flop synchroniser plus a filtered output flop for a level input from outside the clock domain
`timescale 1ns/1ps
module wacdr_sync (
  input  wire pclk,
  input  wire presetn,
  input  wire din,
  output reg  dout
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout   <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule // wacdr_sync

// file: hw/wacdr_byte_reader.v
// byte-stream reader: walks descriptor addresses and returns bytes on request
`timescale 1ns/1ps
module wacdr_byte_reader (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       start,
  input  wire [7:0] start_index,
  input  wire [7:0] limit,
  input  wire       advance,
  input  wire [7:0] rom_byte,
  output reg  [7:0] rd_index,
  output reg  [7:0] rd_data,
  output reg        rd_valid,
  output wire       rd_done
);
  assign rd_done = (rd_index >= limit);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_index <= 8'h00;
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else if (start) begin
      rd_index <= start_index;
      rd_valid <= 1'b0;
    end else if (advance && !rd_done) begin
      rd_data  <= rom_byte;
      rd_valid <= 1'b1;
      rd_index <= rd_index + 8'h01;
    end else if (advance) begin
      rd_valid <= 1'b0;
    end
  end
endmodule // wacdr_byte_reader

// file: hw/wacdr_top.v
// wire adapter configuration descriptor rom with apb control and byte port
`timescale 1ns/1ps
`include "wacdr_defs.vh"
module wacdr_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        high_speed,
  input  wire        self_powered,
  input  wire        ep0_req,
  input  wire        ep0_other_speed,
  input  wire        ep0_next,
  output wire [7:0]  ep0_data,
  output wire        ep0_valid,
  output wire        ep0_last
);
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_SEND = 2'b10;
  // descriptors sit back to back, each base follows from the lengths before it
  localparam [7:0] SEC_BASE = `WACDR_CFG_LEN;
  localparam [7:0] ENC_BASE = SEC_BASE + `WACDR_SEC_LEN;
  localparam [7:0] IF_BASE  = ENC_BASE + `WACDR_ENC_COUNT * `WACDR_ENC_LEN;
  localparam [7:0] WA_BASE  = IF_BASE + `WACDR_IF_LEN;
  localparam [7:0] EP_BASE  = WA_BASE + `WACDR_WA_LEN;
  localparam [15:0] SEC_TOTAL = {8'h00, `WACDR_SEC_LEN}
                              + `WACDR_ENC_COUNT * {8'h00, `WACDR_ENC_LEN};
  localparam [7:0] SET_LEN = EP_BASE + `WACDR_EP_BYTES;
  localparam [15:0] WA_RELEASE = `WACDR_WA_RELEASE;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg         hs_lock_reg;
  reg         os_lock_reg;
  reg  [7:0]  maxpwr_hs_reg;
  reg  [7:0]  maxpwr_fs_reg;
  reg  [7:0]  ports_reg;
  reg  [15:0] pipes_reg;
  reg  [15:0] blocks_reg;
  reg  [7:0]  blk_code_reg;
  reg  [7:0]  ie_count_reg;
  reg  [7:0]  cfg_value_reg;
  reg  [7:0]  num_if_reg;
  reg  [7:0]  cipher_a_reg;
  reg  [7:0]  cipher_b_reg;
  reg  [7:0]  sent_count_reg;
  reg  [7:0]  rom_byte;
  reg  [7:0]  attr_byte;
  reg  [7:0]  power_byte;
  reg  [7:0]  enc_off;
  reg  [7:0]  sec_off;
  reg  [7:0]  if_off;
  reg  [7:0]  wa_off;
  reg  [7:0]  enc_pos;
  reg         enc_second;
  reg  [31:0] rdata_next;
  wire [7:0]  rd_index;
  wire [7:0]  rd_data;
  wire        rd_valid;
  wire        rd_done;
  wire        hs_sync;
  wire        sp_sync;
  wire        bus_wr;
  wire        mapped;
  wire        hit_ctrl;
  wire        hit_maxpwr;
  wire        hit_class0;
  wire        hit_class1;
  wire        hit_status;
  wire        hit_read;
  wire        start;
  wire        advance;
  wire        use_hs;
  wire [15:0] total_len;

  // speed and power pins cross in from outside the clock domain
  wacdr_sync u_sync_hs (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (high_speed),
    .dout    (hs_sync)
  );

  wacdr_sync u_sync_sp (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (self_powered),
    .dout    (sp_sync)
  );

  assign pready  = 1'b1;
  assign hit_ctrl   = (paddr == `WACDR_REG_CTRL);
  assign hit_maxpwr = (paddr == `WACDR_REG_MAXPWR);
  assign hit_class0 = (paddr == `WACDR_REG_CLASS0);
  assign hit_class1 = (paddr == `WACDR_REG_CLASS1);
  assign hit_status = (paddr == `WACDR_REG_STATUS);
  assign hit_read   = (paddr == `WACDR_REG_READ);
  // status and read are mapped but read only, a write there is dropped quietly
  assign mapped     = hit_ctrl || hit_maxpwr || hit_class0 || hit_class1 ||
                      hit_status || hit_read;

  assign pslverr = psel && penable && !mapped;
  assign bus_wr  = psel && penable && pwrite && mapped;

  // software settings steer the descriptor image
  // each register is written whole apart from a zero ie count, there are no byte strobes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maxpwr_hs_reg <= `WACDR_RST_MAXPWR_HS;
      maxpwr_fs_reg <= `WACDR_RST_MAXPWR_FS;
      ports_reg     <= `WACDR_RST_PORTS;
      pipes_reg     <= `WACDR_RST_PIPES;
      blocks_reg    <= `WACDR_RST_BLOCKS;
      blk_code_reg  <= `WACDR_RST_BLK_CODE;
      ie_count_reg  <= `WACDR_RST_IE_COUNT;
      cfg_value_reg <= `WACDR_RST_CFG_VALUE;
      num_if_reg    <= `WACDR_RST_NUM_IF;
      cipher_a_reg  <= 8'h00;
      cipher_b_reg  <= 8'h01;
    end else if (bus_wr) begin
      case (paddr)
        `WACDR_REG_CTRL: begin
          cfg_value_reg <= pwdata[7:0];
          num_if_reg    <= pwdata[15:8];
          cipher_a_reg  <= pwdata[23:16];
          cipher_b_reg  <= pwdata[31:24];
        end
        `WACDR_REG_MAXPWR: begin
          maxpwr_hs_reg <= pwdata[7:0];
          maxpwr_fs_reg <= pwdata[15:8];
        end
        `WACDR_REG_CLASS0: begin
          ports_reg <= pwdata[7:0];
          pipes_reg <= pwdata[31:16];
        end
        `WACDR_REG_CLASS1: begin
          blocks_reg   <= pwdata[15:0];
          blk_code_reg <= pwdata[23:16];
          // a zero count is refused so the descriptor always keeps a usable value
          if (pwdata[31:24] != 8'h00) begin
            ie_count_reg <= pwdata[31:24];
          end
        end
        default: begin
          ie_count_reg <= ie_count_reg;
        end
      endcase
    end
  end

  always @* begin
    case (paddr)
      `WACDR_REG_CTRL:   rdata_next = {cipher_b_reg, cipher_a_reg, num_if_reg, cfg_value_reg};
      `WACDR_REG_MAXPWR: rdata_next = {16'h0000, maxpwr_fs_reg, maxpwr_hs_reg};
      `WACDR_REG_CLASS0: rdata_next = {pipes_reg, 8'h00, ports_reg};
      `WACDR_REG_CLASS1: rdata_next = {ie_count_reg, blk_code_reg, blocks_reg};
      `WACDR_REG_STATUS: rdata_next = {8'h00, sent_count_reg, SET_LEN,
                                       4'h0, sp_sync, hs_sync, state_reg};
      `WACDR_REG_READ:   rdata_next = {24'h0000_00, rd_data};
      default:           rdata_next = 32'h0000_0000;
    endcase
  end

  // read data is captured in the setup phase, so it stands as a flop output
  // through the access phase while pready stays high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rdata_next;
    end
  end

  // other-speed image describes the speed not in use
  assign use_hs = os_lock_reg ? !hs_lock_reg : hs_lock_reg;
  // total length also counts the endpoint descriptors served after this set
  assign total_len = {8'h00, SET_LEN};

  always @* begin
    // reserved bits stay zero, bits 7 and 5 are always one
    attr_byte = 8'h00;
    attr_byte[`WACDR_ATTR_ONE_BIT]  = 1'b1;
    attr_byte[`WACDR_ATTR_SELF_BIT] = sp_sync;
    attr_byte[`WACDR_ATTR_WAKE_BIT] = 1'b1;
    power_byte = use_hs ? maxpwr_hs_reg : maxpwr_fs_reg;
  end

  // descriptor image, one byte per index, low byte first
  always @* begin
    sec_off    = rd_index - SEC_BASE;
    enc_off    = rd_index - ENC_BASE;
    if_off     = rd_index - IF_BASE;
    wa_off     = rd_index - WA_BASE;
    // two encryption descriptors share one layout, the second is picked by range
    enc_second = (enc_off >= `WACDR_ENC_LEN);
    enc_pos    = enc_second ? enc_off - `WACDR_ENC_LEN : enc_off;
    rom_byte   = 8'h00;
    if (rd_index < SEC_BASE) begin
      case (rd_index[3:0])
        4'h0: rom_byte = `WACDR_CFG_LEN;
        4'h1: rom_byte = os_lock_reg ? `WACDR_OSC_TYPE : `WACDR_CFG_TYPE;
        4'h2: rom_byte = total_len[7:0];
        4'h3: rom_byte = total_len[15:8];
        4'h4: rom_byte = num_if_reg;
        4'h5: rom_byte = cfg_value_reg;
        4'h6: rom_byte = 8'h00;
        4'h7: rom_byte = attr_byte;
        4'h8: rom_byte = power_byte;
        default: rom_byte = 8'h00;
      endcase
    end else if (rd_index < ENC_BASE) begin
      case (sec_off)
        8'h00: rom_byte = `WACDR_SEC_LEN;
        8'h01: rom_byte = `WACDR_SEC_TYPE;
        8'h02: rom_byte = SEC_TOTAL[7:0];
        8'h03: rom_byte = SEC_TOTAL[15:8];
        default: rom_byte = `WACDR_ENC_COUNT;
      endcase
    end else if (rd_index < IF_BASE) begin
      case (enc_pos)
        8'h00: rom_byte = `WACDR_ENC_LEN;
        8'h01: rom_byte = `WACDR_ENC_TYPE;
        8'h02: rom_byte = enc_second ? 8'h01 : 8'h00;
        8'h03: rom_byte = enc_second ? cipher_b_reg : cipher_a_reg;
        default: rom_byte = `WACDR_KEY_INDEX;
      endcase
    end else if (rd_index < WA_BASE) begin
      case (if_off)
        8'h00: rom_byte = `WACDR_IF_LEN;
        8'h01: rom_byte = `WACDR_IF_TYPE;
        8'h02: rom_byte = `WACDR_IF_NUM;
        8'h03: rom_byte = `WACDR_IF_ALT;
        8'h04: rom_byte = `WACDR_IF_NUM_EP;
        8'h05: rom_byte = `WACDR_IF_CLASS;
        8'h06: rom_byte = `WACDR_IF_SUBCLASS;
        8'h07: rom_byte = `WACDR_IF_PROTOCOL;
        default: rom_byte = 8'h00;
      endcase
    end else if (rd_index < EP_BASE) begin
      case (wa_off)
        8'h00: rom_byte = `WACDR_WA_LEN;
        8'h01: rom_byte = `WACDR_WA_TYPE;
        8'h02: rom_byte = WA_RELEASE[7:0];
        8'h03: rom_byte = WA_RELEASE[15:8];
        8'h04: rom_byte = ports_reg;
        8'h05: rom_byte = `WACDR_WA_ATTR;
        8'h06: rom_byte = pipes_reg[7:0];
        8'h07: rom_byte = pipes_reg[15:8];
        8'h08: rom_byte = blocks_reg[7:0];
        8'h09: rom_byte = blocks_reg[15:8];
        8'h0a: rom_byte = blk_code_reg;
        8'h0b: rom_byte = `WACDR_WA_POWER_GOOD;
        8'h0c: rom_byte = ie_count_reg;
        default: rom_byte = `WACDR_WA_REMOVABLE;
      endcase
    end
  end

  // endpoint-zero fetch sequencer
  // a request while sending is ignored; the host asks again once idle
  assign start   = (state_reg == ST_IDLE) && ep0_req;
  assign advance = (state_reg == ST_SEND) && (ep0_next || !rd_valid);

  always @* begin
    case (state_reg)
      ST_IDLE: state_next = ep0_req ? ST_SEND : ST_IDLE;
      ST_SEND: state_next = (rd_done && ep0_next) ? ST_IDLE : ST_SEND;
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= ST_IDLE;
      hs_lock_reg    <= 1'b0;
      os_lock_reg    <= 1'b0;
      sent_count_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      // speed and header kind are frozen for the whole stream so it cannot tear
      if (start) begin
        hs_lock_reg    <= hs_sync;
        os_lock_reg    <= ep0_other_speed;
        sent_count_reg <= 8'h00;
      end else if (ep0_valid && ep0_next) begin
        sent_count_reg <= sent_count_reg + 8'h01;
      end
    end
  end

  // the reader stops before the endpoint descriptors, which are served elsewhere
  wacdr_byte_reader u_reader (
    .pclk        (pclk),
    .presetn     (presetn),
    .start       (start),
    .start_index (8'h00),
    .limit       (EP_BASE),
    .advance     (advance),
    .rom_byte    (rom_byte),
    .rd_index    (rd_index),
    .rd_data     (rd_data),
    .rd_valid    (rd_valid),
    .rd_done     (rd_done)
  );

  // a byte stands until taken; ep0_last marks the final one
  assign ep0_data  = rd_data;
  assign ep0_valid = (state_reg == ST_SEND) && rd_valid;
  assign ep0_last  = ep0_valid && rd_done;
endmodule // wacdr_top

// file: dv/wacdr_checker_assertions.sv
// checker for the descriptor byte port of the rom
`timescale 1ns/1ps
module wacdr_checker (
  input wire       pclk,
  input wire       presetn,
  input wire [7:0] ep0_data,
  input wire       ep0_valid,
  input wire       ep0_last,
  input wire       ep0_next
);
  logic [7:0] idx_reg;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // position of the byte now offered, counted from the stream start
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      idx_reg <= 8'h00;
    else if (!ep0_valid)
      idx_reg <= 8'h00;
    else if (ep0_next)
      idx_reg <= idx_reg + 8'h01;
  end
  sequence s_accept;
    ep0_valid && ep0_next;
  endsequence
  a_first_len: assert property ($rose(ep0_valid) |-> ep0_data == 8'h09)
    else $error("first byte is not the header length");
  a_header_type: assert property (ep0_valid && idx_reg == 8'd1 |->
    ep0_data == 8'h02 || ep0_data == 8'h07)
    else $error("header type byte wrong");
  a_attr_bits: assert property (ep0_valid && idx_reg == 8'd7 |->
    ep0_data[7] && ep0_data[5] && ep0_data[4:0] == 5'h00)
    else $error("attribute byte wrong");
  a_sec_type: assert property (ep0_valid && idx_reg == 8'd10 |-> ep0_data == 8'h0c)
    else $error("security type byte wrong");
  a_key_zero: assert property (ep0_valid && (idx_reg == 8'd18 || idx_reg == 8'd23) |->
    ep0_data == 8'h00)
    else $error("key index not zero");
  a_if_class: assert property (ep0_valid && idx_reg == 8'd29 |-> ep0_data == 8'he0)
    else $error("interface class wrong");
  a_class_type: assert property (ep0_valid && idx_reg == 8'd34 |-> ep0_data == 8'h21)
    else $error("class descriptor type wrong");
  a_power_good: assert property (ep0_valid && idx_reg == 8'd44 |-> ep0_data == 8'h00)
    else $error("power good byte not zero");
  a_ie_nonzero: assert property (ep0_valid && idx_reg == 8'd45 |-> ep0_data != 8'h00)
    else $error("schedule block count zero");
  a_removable_zero: assert property (ep0_valid && idx_reg == 8'd46 |-> ep0_data == 8'h00)
    else $error("removable map not zero");
  a_byte_hold: assert property (ep0_valid && !ep0_next |=> ep0_valid && $stable(ep0_data))
    else $error("byte changed before accepted");
  a_last_count: assert property (ep0_last |-> ep0_valid && idx_reg == 8'd46)
    else $error("last byte at wrong position");
  a_last_end: assert property (s_accept ##0 ep0_last |=> !ep0_valid)
    else $error("stream continued after last byte");
endmodule // wacdr_checker
bind wacdr_top wacdr_checker u_chk (
  .pclk(pclk), .presetn(presetn), .ep0_data(ep0_data),
  .ep0_valid(ep0_valid), .ep0_last(ep0_last), .ep0_next(ep0_next));

// file: dv/wacdr_host.sv
// host-side model that requests and collects the descriptor set
`timescale 1ns/1ps
module wacdr_host (
  input wire        pclk,
  input wire        presetn,
  input wire        go,
  input wire        slow,
  input wire  [7:0] ep0_data,
  input wire        ep0_valid,
  input wire        ep0_last,
  output logic      ep0_req,
  output logic      ep0_next
);
  logic [7:0] got [0:63];
  logic [7:0] cnt;
  logic       busy;
  // one fetch at a time over the control endpoint; slow accepts every other cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep0_req  <= 1'b0;
      ep0_next <= 1'b0;
      busy     <= 1'b0;
      cnt      <= 8'h00;
    end else begin
      ep0_req  <= go && !busy;
      ep0_next <= !slow || !ep0_next;
      if (go && !busy) begin
        busy <= 1'b1;
        cnt  <= 8'h00;
      end
      if (ep0_valid && ep0_next) begin
        got[cnt] <= ep0_data;
        cnt      <= cnt + 8'h01;
        if (ep0_last)
          busy <= 1'b0;
      end
    end
  end
endmodule // wacdr_host

// file: dv/tb.sv
// self-checking bench for the wire adapter descriptor rom
`timescale 1ns/1ps
`include "wacdr_defs.vh"
module tb;
  localparam logic [375:0] EXP = {72'h09_0244_0002_0100_a032, 40'h05_0c0f_0002,
    80'h050e_0011_0005_0e01_2200, 72'h09_0400_0003_e002_0100,
    112'h0e21_0001_7f00_1000_8000_0a00_0400};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        hs_pin = 1'b0;
  logic        sp_pin = 1'b0;
  logic        other = 1'b0;
  logic        go = 1'b0;
  logic        slow = 1'b0;
  wire  [31:0] prdata;
  wire         pready, pslverr, ep0_req, ep0_next, ep0_valid, ep0_last;
  wire  [7:0]  ep0_data;
  int          bad_count = 0;
  int          tests_run = 0;
  logic [31:0] rd;
  logic        er;
  always #10 pclk = ~pclk;
  wacdr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .high_speed(hs_pin), .self_powered(sp_pin), .ep0_req(ep0_req),
    .ep0_other_speed(other), .ep0_next(ep0_next), .ep0_data(ep0_data),
    .ep0_valid(ep0_valid), .ep0_last(ep0_last));
  wacdr_host u_host (.pclk(pclk), .presetn(presetn), .go(go), .slow(slow),
    .ep0_data(ep0_data), .ep0_valid(ep0_valid), .ep0_last(ep0_last),
    .ep0_req(ep0_req), .ep0_next(ep0_next));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      bad_count++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic fetch(input logic hs, os, sp, sl, input logic [7:0] ie);
    int n;
    logic [7:0] e;
    hs_pin <= hs;
    sp_pin <= sp;
    other  <= os;
    slow   <= sl;
    repeat (6) @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (u_host.busy && n < 400);
    if (u_host.busy) begin
      bad_count++;
      finish_test();
    end
    check("stream length", {24'h0, u_host.cnt}, 32'h0000_002f);
    apb(1'b0, `WACDR_REG_STATUS, 32'h0);
    check("status", rd, {8'h00, 8'h2f, 8'h44, 4'h0, sp, hs, 2'b01});
    apb(1'b0, `WACDR_REG_READ, 32'h0);
    check("last byte", rd, 32'h0000_0000);
    for (int i = 0; i < 47; i++) begin
      e = EXP[375 - 8*i -: 8];
      if (i == 1) e = os ? 8'h07 : 8'h02;
      if (i == 7) e = sp ? 8'he0 : 8'ha0;
      if (i == 8) e = (hs ^ os) ? 8'h64 : 8'h19;
      if (i == 45) e = ie;
      if (i != 6 && i != 32)
        check($sformatf("byte %0d", i), {24'h0, u_host.got[i]}, {24'h0, e});
    end
  endtask
  task automatic test_regs();
    apb(1'b0, `WACDR_REG_MAXPWR, 32'h0);
    check("maxpwr reset", rd, 32'h0000_3232);
    apb(1'b0, `WACDR_REG_CLASS0, 32'h0);
    check("class0 reset", rd, 32'h0010_007f);
    apb(1'b0, `WACDR_REG_CLASS1, 32'h0);
    check("class1 reset", rd, 32'h040a_0080);
    apb(1'b1, 12'h018, 32'h1234_5678);
    check("unmapped write error", {31'h0, er}, 32'h1);
    apb(1'b0, 12'h018, 32'h0);
    check("unmapped read error", {31'h0, er}, 32'h1);
    check("unmapped read data", rd, 32'h0);
    $display("test regs done");
  endtask
  task automatic test_setup();
    apb(1'b1, `WACDR_REG_CTRL, 32'h2211_0201);
    apb(1'b0, `WACDR_REG_CTRL, 32'h0);
    check("ctrl readback", rd, 32'h2211_0201);
    apb(1'b1, `WACDR_REG_MAXPWR, 32'h0000_1964);
    apb(1'b1, `WACDR_REG_CLASS1, 32'h000a_0080);
    apb(1'b0, `WACDR_REG_CLASS1, 32'h0);
    check("zero ie count kept", rd, 32'h040a_0080);
    $display("test setup done");
  endtask
  task automatic test_high_speed();
    fetch(1'b1, 1'b0, 1'b1, 1'b0, 8'h04);
    $display("test high speed done");
  endtask
  task automatic test_other_speed();
    fetch(1'b1, 1'b1, 1'b0, 1'b1, 8'h04);
    $display("test other speed stalled done");
  endtask
  task automatic test_full_speed();
    apb(1'b1, `WACDR_REG_CLASS1, 32'h070a_0080);
    fetch(1'b0, 1'b0, 1'b0, 1'b0, 8'h07);
    $display("test full speed done");
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_setup();
    test_high_speed();
    test_other_speed();
    test_full_speed();
    finish_test();
  end
endmodule // tb
